// *** hdl/atfs_one_shot.sv ***
// Retrigger-proof one-shot pulse timer
`timescale 1ns/1ns
module atfs_one_shot
	import atfs_pkg::*;
#(
	parameter int COUNT = ATFS_SHOT_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	atfs_shot_if.tmr  shot
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	atfs_shot_state_type state_r;
	atfs_shot_state_type state_nxt;
	logic [CW-1:0]       cnt_r;
	logic [CW-1:0]       cnt_nxt;

	// A fire during a pulse is dropped so the pulse stays single
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ATFS_SHOT_IDLE: begin
				if (shot.fire) begin
					state_nxt = ATFS_SHOT_BUSY;
					cnt_nxt   = '0;
				end
			end
			ATFS_SHOT_BUSY: begin
				if (cnt_r == LAST) begin // R3
					state_nxt = ATFS_SHOT_IDLE;
				end else begin
					cnt_nxt = cnt_r + CW'(1);
				end
			end
			default: begin
				state_nxt = ATFS_SHOT_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ATFS_SHOT_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign shot.pulse = (state_r == ATFS_SHOT_BUSY);
endmodule

// *** hdl/atfs_pkg.sv ***
// Constants and types for the per-axis terminal function select block
// What this block does
// [R1] Mode code 00 makes a terminal a general-purpose input and code 01 a general-purpose output.
// [R2] Terminal 1 with mode 10 is driven with the decelerating flag.
// [R3] Terminal 1 with mode 11 gives a single one-shot pulse of 26 ms.
// [R4] The terminal-2 mode is taken from bits 4 and 5 of the terminal configuration register.
// [R5] Terminal 2 with mode 10 shows the constant-speed flag active low.
// [R6] Terminal 2 with mode 11 shows the constant-speed flag active high.
// [R7] Terminal 3 shows comparator-1 match, active low for 10 and active high for 11.
// [R8] Terminal 4 mode sits in bits 8 and 9 and shows comparator-2 match, low for 10, high for 11.
// [R9] Terminal 5 shows comparator-3 match, active low for 10 and active high for 11.
// [R10] Terminal 6 mode sits in bits 12 and 13 and shows comparator-4 match, low 10, high 11.
// [R11] Terminal 7 shows comparator-5 match, active low for 10 and active high for 11.
// [R12] The terminal-0 polarity bit makes its speed-up or one-shot output active low at 0, high at 1.
// [R13] In input mode the terminal driver is off and software reads the sampled pin level.
package atfs_pkg;
	localparam int          ATFS_NUM_TERM     = 8;
	localparam int          ATFS_ADDR_W       = 8;
	localparam int          ATFS_DATA_W       = 32;
	// Register offsets
	localparam logic [7:0]  ATFS_OFS_TERM_CFG = 8'h00;
	localparam logic [7:0]  ATFS_OFS_CTRL     = 8'h04;
	localparam logic [7:0]  ATFS_OFS_GP_OUT   = 8'h08;
	localparam logic [7:0]  ATFS_OFS_GP_IN    = 8'h0C;
	localparam logic [7:0]  ATFS_OFS_SHOT     = 8'h10;
	// Field layout
	localparam int          ATFS_MODE_W       = 2;
	localparam int          ATFS_TERM2_POS    = 4;
	localparam int          ATFS_TERM4_POS    = 8;
	localparam int          ATFS_TERM6_POS    = 12;
	localparam int          ATFS_POL_BIT      = 0;
	localparam int          ATFS_NUM_SHOT     = 2;
	// Reset values
	localparam logic [15:0] ATFS_TERM_CFG_RST = 16'h0000;
	localparam logic        ATFS_POL_RST      = 1'b0;
	localparam logic [7:0]  ATFS_GP_OUT_RST   = 8'h00;
	// Timing
	localparam int          ATFS_CLK_HZ       = 50_000_000;
	localparam int          ATFS_SHOT_MS      = 26;
	localparam int          ATFS_SHOT_CYC     = (ATFS_CLK_HZ / 1000) * ATFS_SHOT_MS;

	typedef enum logic [1:0] {
		ATFS_MODE_GP_IN  = 2'b00,
		ATFS_MODE_GP_OUT = 2'b01,
		ATFS_MODE_FUNC_A = 2'b10,
		ATFS_MODE_FUNC_B = 2'b11
	} atfs_mode_type;

	typedef enum logic [0:0] {
		ATFS_SHOT_IDLE = 1'b0,
		ATFS_SHOT_BUSY = 1'b1
	} atfs_shot_state_type;
endpackage

// *** hdl/atfs_shot_if.sv ***
// Trigger and pulse pair between the top and one one-shot timer
`timescale 1ns/1ns
interface atfs_shot_if;
	logic fire;
	logic pulse;
	modport ctl (output fire, input pulse);
	modport tmr (input fire, output pulse);
endinterface

// *** hdl/atfs_top.sv ***
// Terminal function select for one axis with its register port
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
module atfs_top
	import atfs_pkg::*;
#(
	parameter int SHOT_CYC = ATFS_SHOT_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [ATFS_ADDR_W-1:0]   addr,
	input  wire logic [ATFS_DATA_W-1:0]   wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [ATFS_DATA_W-1:0]   rdata,
	input  wire logic                     accelerating_flag,
	input  wire logic                     decelerating_flag,
	input  wire logic                     constant_speed_flag,
	input  wire logic                     compare1_match_out,
	input  wire logic                     compare2_match_out,
	input  wire logic                     compare3_match_out,
	input  wire logic                     compare4_match_out,
	input  wire logic                     compare5_match_out,
	input  wire logic [ATFS_NUM_TERM-1:0] term_in,
	output logic      [ATFS_NUM_TERM-1:0] term_out,
	output logic      [ATFS_NUM_TERM-1:0] term_oe
);
	localparam int CFG_W = ATFS_NUM_TERM * ATFS_MODE_W;

	logic [CFG_W-1:0]         term_cfg_r;
	logic [CFG_W-1:0]         term_cfg_nxt;
	logic                     term0_output_polarity_r;
	logic                     term0_output_polarity_nxt;
	logic [ATFS_NUM_TERM-1:0] gp_out_r;
	logic [ATFS_NUM_TERM-1:0] gp_out_nxt;
	logic [ATFS_NUM_TERM-1:0] gp_in_r;
	logic [ATFS_DATA_W-1:0]   rdata_r;
	logic [ATFS_DATA_W-1:0]   rdata_nxt;
	logic [ATFS_NUM_TERM-1:0] pin_out_r;
	logic [ATFS_NUM_TERM-1:0] pin_out_nxt;
	logic [ATFS_NUM_TERM-1:0] pin_oe_r;
	logic [ATFS_NUM_TERM-1:0] pin_oe_nxt;
	logic [ATFS_NUM_TERM-1:0] func_sig;
	logic [ATFS_NUM_SHOT-1:0] shot_fire;
	logic [ATFS_NUM_SHOT-1:0] shot_pulse;

	assign func_sig = {compare5_match_out, compare4_match_out, compare3_match_out,
		compare2_match_out, compare1_match_out, constant_speed_flag,
		decelerating_flag, accelerating_flag};

	// Register writes
	always_comb begin
		term_cfg_nxt              = term_cfg_r;
		term0_output_polarity_nxt = term0_output_polarity_r;
		gp_out_nxt                = gp_out_r;
		shot_fire                 = '0;
		if (wr) begin
			case (addr)
				ATFS_OFS_TERM_CFG: term_cfg_nxt = wdata[CFG_W-1:0];
				ATFS_OFS_CTRL:     term0_output_polarity_nxt = wdata[ATFS_POL_BIT];
				ATFS_OFS_GP_OUT:   gp_out_nxt = wdata[ATFS_NUM_TERM-1:0];
				ATFS_OFS_SHOT:     shot_fire = wdata[ATFS_NUM_SHOT-1:0];
				default: begin
				end
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		if (rd) begin
			case (addr)
				ATFS_OFS_TERM_CFG: rdata_nxt = {{(ATFS_DATA_W-CFG_W){1'b0}}, term_cfg_r};
				ATFS_OFS_CTRL:     rdata_nxt = {{(ATFS_DATA_W-1){1'b0}}, term0_output_polarity_r};
				ATFS_OFS_GP_OUT:   rdata_nxt = {{(ATFS_DATA_W-ATFS_NUM_TERM){1'b0}}, gp_out_r};
				ATFS_OFS_GP_IN:    rdata_nxt = {{(ATFS_DATA_W-ATFS_NUM_TERM){1'b0}}, gp_in_r}; // R13
				ATFS_OFS_SHOT:     rdata_nxt = {{(ATFS_DATA_W-ATFS_NUM_SHOT){1'b0}}, shot_pulse};
				default:           rdata_nxt = '0;
			endcase
		end
	end

	// One-shot timers for terminals 0 and 1
	for (genvar s = 0; s < ATFS_NUM_SHOT; s++) begin : g_shot
		atfs_shot_if shot_bus ();
		assign shot_bus.fire = shot_fire[s];
		assign shot_pulse[s] = shot_bus.pulse;
		atfs_one_shot #(
			.COUNT (SHOT_CYC)
		) u_shot (
			.clk  (clk),
			.rst  (rst),
			.shot (shot_bus.tmr)
		);
	end

	// Per-terminal output select; pins are registered to avoid decode glitches
	for (genvar i = 0; i < ATFS_NUM_TERM; i++) begin : g_term
		atfs_mode_type mode;
		assign mode = atfs_mode_type'(term_cfg_r[i*ATFS_MODE_W +: ATFS_MODE_W]); // R4 R8 R10
		always_comb begin
			pin_oe_nxt[i]  = 1'b1;
			pin_out_nxt[i] = 1'b0;
			case (mode)
				ATFS_MODE_GP_IN: begin
					pin_oe_nxt[i] = 1'b0; // R1 R13
				end
				ATFS_MODE_GP_OUT: begin
					pin_out_nxt[i] = gp_out_r[i]; // R1
				end
				ATFS_MODE_FUNC_A: begin
					if (i == 0) begin
						pin_out_nxt[i] = func_sig[i] ~^ term0_output_polarity_r; // R12
					end else if (i == 1) begin
						pin_out_nxt[i] = func_sig[i]; // R2
					end else begin
						pin_out_nxt[i] = ~func_sig[i]; // R5 R7 R8 R9 R10 R11
					end
				end
				ATFS_MODE_FUNC_B: begin
					if (i == 0) begin
						pin_out_nxt[i] = shot_pulse[0] ~^ term0_output_polarity_r; // R12
					end else if (i == 1) begin
						pin_out_nxt[i] = shot_pulse[1]; // R3
					end else begin
						pin_out_nxt[i] = func_sig[i]; // R6 R7 R8 R9 R10 R11
					end
				end
				default: begin
					pin_oe_nxt[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			term_cfg_r              <= ATFS_TERM_CFG_RST;
			term0_output_polarity_r <= ATFS_POL_RST;
			gp_out_r                <= ATFS_GP_OUT_RST;
			gp_in_r                 <= '0;
			rdata_r                 <= '0;
			pin_out_r               <= '0;
			pin_oe_r                <= '0;
		end else begin
			term_cfg_r              <= term_cfg_nxt;
			term0_output_polarity_r <= term0_output_polarity_nxt;
			gp_out_r                <= gp_out_nxt;
			gp_in_r                 <= term_in; // R13
			rdata_r                 <= rdata_nxt;
			pin_out_r               <= pin_out_nxt;
			pin_oe_r                <= pin_oe_nxt;
		end
	end

	assign rdata    = rdata_r;
	assign term_out = pin_out_r;
	assign term_oe  = pin_oe_r;
endmodule

// *** tb/atfs_checker.sv ***
// Concurrent checks on the terminal function select ports
`timescale 1ns/1ns
module atfs_checker
	import atfs_pkg::*;
#(
	parameter int SHOT_CYC = ATFS_SHOT_CYC
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        accelerating_flag,
	input wire logic        decelerating_flag,
	input wire logic        constant_speed_flag,
	input wire logic        compare1_match_out,
	input wire logic        compare2_match_out,
	input wire logic        compare3_match_out,
	input wire logic        compare4_match_out,
	input wire logic        compare5_match_out,
	input wire logic [7:0]  term_in,
	input wire logic [7:0]  term_out,
	input wire logic [7:0]  term_oe
);
	logic [15:0] m_r;
	logic        pol_r;
	int          hi_r;
	// Shadow of mode and polarity, so outputs can be tied to what software wrote
	always_ff @(posedge clk) begin
		if (rst) begin
			m_r <= 16'h0000;
			pol_r <= 1'b0;
		end else if (wr && addr == ATFS_OFS_TERM_CFG) begin
			m_r <= wdata[15:0];
		end else if (wr && addr == ATFS_OFS_CTRL) begin
			pol_r <= wdata[0];
		end
		hi_r <= (rst || !term_out[1]) ? 0 : hi_r + 1;
	end
	function automatic logic [7:0] oe_of(input logic [15:0] c);
		for (int i = 0; i < 8; i++) oe_of[i] = |c[2*i+:2];
	endfunction
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_shot_end;
		$fell(term_out[1]) ##0 $past(m_r[3:2]) == 2'b11;
	endsequence
	a_oe_by_mode: assert property (term_oe == oe_of($past(m_r)))
		else $error("term_oe wrong");
	a_decel_out: assert property ($past(m_r[3:2]) == 2'b10 |->
		term_out[1] == $past(decelerating_flag)) else $error("term1 wrong");
	a_cspeed_low: assert property ($past(m_r[5:4]) == 2'b10 |->
		term_out[2] == !$past(constant_speed_flag)) else $error("term2 low wrong");
	a_cspeed_high: assert property ($past(m_r[5:4]) == 2'b11 |->
		term_out[2] == $past(constant_speed_flag)) else $error("term2 high wrong");
	a_cmp1_out: assert property ($past(m_r[7]) |->
		term_out[3] == ($past(compare1_match_out) ^ !$past(m_r[6]))) else $error("term3 wrong");
	a_cmp2_out: assert property ($past(m_r[9]) |->
		term_out[4] == ($past(compare2_match_out) ^ !$past(m_r[8]))) else $error("term4 wrong");
	a_cmp3_out: assert property ($past(m_r[11]) |->
		term_out[5] == ($past(compare3_match_out) ^ !$past(m_r[10]))) else $error("term5 wrong");
	a_cmp4_out: assert property ($past(m_r[13]) |->
		term_out[6] == ($past(compare4_match_out) ^ !$past(m_r[12]))) else $error("term6 wrong");
	a_cmp5_out: assert property ($past(m_r[15]) |->
		term_out[7] == ($past(compare5_match_out) ^ !$past(m_r[14]))) else $error("term7 wrong");
	a_accel_pol: assert property ($past(m_r[1:0]) == 2'b10 |->
		term_out[0] == ($past(accelerating_flag) ~^ $past(pol_r))) else $error("term0 wrong");
	a_shot_len: assert property (s_shot_end |-> hi_r == SHOT_CYC)
		else $error("pulse length wrong");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("rdata not idle");
endmodule
bind atfs_top atfs_checker #(.SHOT_CYC(SHOT_CYC)) u_atfs_checker (.clk, .rst, .addr, .wdata,
	.wr, .rd, .rdata, .accelerating_flag, .decelerating_flag, .constant_speed_flag,
	.compare1_match_out, .compare2_match_out, .compare3_match_out, .compare4_match_out,
	.compare5_match_out, .term_in, .term_out, .term_oe);

// *** tb/atfs_pin_model.sv ***
// Pin-side equipment model that resolves each terminal wire
`timescale 1ns/1ns
module atfs_pin_model (
	input  wire logic [7:0] term_out,
	input  wire logic [7:0] term_oe,
	input  wire logic [7:0] ext_drive,
	output logic      [7:0] term_in
);
	// Equipment drives only released pins, so the wire never sees contention
	assign term_in = (term_oe & term_out) | (~term_oe & ext_drive);
endmodule

// *** tb/atfs_top_tb.sv ***
// Self-checking bench for the terminal function select block
`timescale 1ns/1ns
module atfs_top_tb
	import atfs_pkg::*;
;
	localparam int SC = 20;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic        hold = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  ext = 8'h00;
	logic [7:0]  st = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] r;
	logic [31:0] rdata;
	logic [7:0]  t_out;
	logic [7:0]  t_oe;
	logic [7:0]  t_in;
	logic [31:0] exp_q[$];
	int          err_total = 0;
	int          cmp_count = 0;
	int          seed = 90;
	int          hi0 = 0;
	atfs_top #(.SHOT_CYC(SC)) u_atfs_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.accelerating_flag(st[0]), .decelerating_flag(st[1]), .constant_speed_flag(st[2]),
		.compare1_match_out(st[3]), .compare2_match_out(st[4]), .compare3_match_out(st[5]),
		.compare4_match_out(st[6]), .compare5_match_out(st[7]), .term_in(t_in),
		.term_out(t_out), .term_oe(t_oe));
	atfs_pin_model u_atfs_pin_model (.term_out(t_out), .term_oe(t_oe), .ext_drive(ext),
		.term_in(t_in));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [7:0] oe_of(input logic [15:0] c);
		for (int i = 0; i < 8; i++) oe_of[i] = c[2*i] | c[2*i+1];
	endfunction
	// Strobes are set on every call, so back-to-back accesses never assign twice
	task automatic bus(input logic w, input logic q, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= q;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		st <= 8'($random(seed));
		if (!hold) ext <= 8'($random(seed));
		if (t_out[0]) hi0++;
		if (rd_q) chk("rdata", exp_q.pop_front(), rdata);
		rd_q <= rd;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		chk("term_oe", 32'h0000_0000, {24'h00_0000, t_oe});
		rd_chk(ATFS_OFS_TERM_CFG, 32'h0000_0000);
		rd_chk(8'h14, 32'h0000_0000);
		bus(1'b1, 1'b0, ATFS_OFS_CTRL, 32'h0000_0001);
		bus(1'b1, 1'b0, ATFS_OFS_TERM_CFG, 32'h0000_000F);
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		hi0 = 0;
		bus(1'b1, 1'b0, ATFS_OFS_SHOT, 32'h0000_0003);
		rd_chk(ATFS_OFS_SHOT, 32'h0000_0003);
		// A fire during the pulse must not stretch it
		bus(1'b1, 1'b0, ATFS_OFS_SHOT, 32'h0000_0003);
		repeat (SC + 4) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		chk("shot length", SC, hi0);
		rd_chk(ATFS_OFS_SHOT, 32'h0000_0000);
		for (int k = 0; k < 40; k++) begin
			r = $random(seed);
			r[3:0] = r[3:0] & ~{r[2], 1'b0, r[0], 1'b0};
			bus(1'b1, 1'b0, ATFS_OFS_TERM_CFG, {16'h0000, r[15:0]});
			bus(1'b1, 1'b0, ATFS_OFS_CTRL, {31'h0000_0000, r[16]});
			rd_chk(ATFS_OFS_TERM_CFG, {16'h0000, r[15:0]});
			repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
			chk("term_oe", {24'h00_0000, oe_of(r[15:0])}, {24'h00_0000, t_oe});
		end
		bus(1'b1, 1'b0, ATFS_OFS_TERM_CFG, 32'h0000_0000);
		hold = 1'b1;
		bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		ext <= r[7:0];
		repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		rd_chk(ATFS_OFS_GP_IN, {24'h00_0000, r[7:0]});
		bus(1'b1, 1'b0, ATFS_OFS_TERM_CFG, 32'h0000_5555);
		bus(1'b1, 1'b0, ATFS_OFS_GP_OUT, {24'h00_0000, ~r[7:0]});
		repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		rd_chk(ATFS_OFS_GP_IN, {24'h00_0000, ~r[7:0]});
		rd_chk(ATFS_OFS_GP_OUT, {24'h00_0000, ~r[7:0]});
		repeat (3) bus(1'b0, 1'b0, 8'h00, 32'h0000_0000);
		complete_run();
	end
	initial begin
		#200_000;
		err_total++;
		complete_run();
	end
endmodule
